/* core/pcs_pkg.sv */
// package of constants for the polling clock sequencer
// assumes one core clock at 25 MHz; no bus, all fields are ports
package pcs_pkg;
  // crystal division factors by division select pin level
  localparam int unsigned DIV_LOW   = 10;
  localparam int unsigned DIV_HIGH  = 14;
  localparam int unsigned DIV_W     = 4;
  // sleep length scale in basic clock periods
  localparam int unsigned SLEEP_UNIT = 1024;
  localparam int unsigned SLEEP_W    = 5;
  localparam logic [4:0]  SLEEP_PERM = 5'h1F;
  // sleep extension factors
  localparam logic [3:0]  XSLEEP_NORM = 4'h1;
  localparam logic [3:0]  XSLEEP_EXT  = 4'h8;
  // start-up length in extended clock periods
  localparam int unsigned STARTUP_XCLK = 16;
  // core clock period in ns
  localparam int unsigned CORE_CLK_NS = 40;
  // sequencer phases
  typedef enum logic [1:0] {PCS_SLEEP, PCS_STARTUP, PCS_CHECK, PCS_RECEIVE} pcs_state_t;
endpackage

/* core/pcs_clk_div.sv */
// basic and extended clock tick generator
// assumes crystal ticks arrive as a one-cycle pulse synchronous to core clock
`timescale 1ns/1ps
module pcs_clk_div (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // crystal tick and selects
  input  wire logic       xtal_tick_i,
  input  wire logic       div_sel_i,
  input  wire logic [1:0] baud_range_select_i,
  // ticks out
  output logic            basic_tick_o,
  output logic            ext_tick_o
);
  logic [pcs_pkg::DIV_W-1:0] div_cnt_r;
  logic [2:0]                xclk_cnt_r;
  wire  [pcs_pkg::DIV_W-1:0] div_last = div_sel_i ? pcs_pkg::DIV_W'(pcs_pkg::DIV_HIGH - 1)
                                                   : pcs_pkg::DIV_W'(pcs_pkg::DIV_LOW - 1);
  // extended period mask: 7,3,1,0 for ranges 0..3
  wire  [2:0]                xclk_last = 3'(3'h7 >> baud_range_select_i);
  wire                       basic_hit = xtal_tick_i && (div_cnt_r >= div_last);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      div_cnt_r    <= '0;
      basic_tick_o <= 1'b0;
    end else begin
      basic_tick_o <= basic_hit;
      if (basic_hit) div_cnt_r <= '0;
      else if (xtal_tick_i) div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      xclk_cnt_r <= '0;
      ext_tick_o <= 1'b0;
    end else begin
      ext_tick_o <= basic_hit && (xclk_cnt_r >= xclk_last);
      if (basic_hit) xclk_cnt_r <= (xclk_cnt_r >= xclk_last) ? 3'h0 : xclk_cnt_r + 1'b1;
    end
  end
endmodule

/* core/pcs_top.sv */
// polling sequencer: sleep, start-up and bit-check phases
// assumes bit-check logic outside reports pass and fail pulses; one clock
//
// Functional notes
// - The basic clock comes from the crystal divided by a factor chosen by the select pin.
// - The extended clock is 8, 4, 2 or 1 basic periods for baud ranges 0 to 3.
// - The basic clock times the sleep phase and, through the extended clock, the start-up phase.
// - In polling mode the sequencer loops sleep, start-up, bit check.
// - Start-up enables signal processing and lets it settle before the check.
// - A failed bit check returns to sleep when the check ends.
// - Transmitter signals are ignored in sleep and start-up.
// - Sleep length is the sleep field times the extension factor times 1024 basic periods.
// - The extension factor is 8 if sticky or temporary extension is set, else 1.
// - Sticky extension extends every sleep.
// - Temporary extension holds while checks pass and self-clears on the first failure.
// - The maximum sleep field value sleeps until another value is written.
// - Two baud bits select the range and scale the start-up length.
// - Check length follows the external pass or fail result in time.
`timescale 1ns/1ps
module pcs_top (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // clock inputs
  input  wire logic       xtal_tick_i,
  input  wire logic       div_sel_i,
  // operating mode register write port
  input  wire logic       operating_mode_register_wr_i,
  input  wire logic [4:0] sleep_field_i,
  input  wire logic       baud_range_bit_low_i,
  input  wire logic       baud_range_bit_high_i,
  input  wire logic       sticky_sleep_extension_i,
  input  wire logic       temporary_sleep_extension_i,
  // polling control and bit-check result
  input  wire logic       polling_en_i,
  input  wire logic       check_pass_i,
  input  wire logic       check_fail_i,
  input  wire logic       rx_data_i,
  // outputs
  output logic            basic_tick_o,
  output logic            ext_tick_o,
  output logic            proc_en_o,
  output logic            check_active_o,
  output logic            rx_data_o,
  output logic            receiving_o,
  output logic            perm_sleep_o,
  output logic            temp_ext_o,
  output logic [1:0]      phase_o
);
  pcs_pkg::pcs_state_t state_r;
  pcs_pkg::pcs_state_t state_nxt;
  logic [4:0]  sleep_field_r;
  logic [1:0]  baud_r;
  logic        sticky_r;
  logic        temp_r;
  logic [17:0] cnt_r;
  logic        basic_tick;
  logic        ext_tick;

  // tick generator
  pcs_clk_div u_div (
    .core_clk_i          (core_clk_i),
    .rstn_i              (rstn_i),
    .xtal_tick_i         (xtal_tick_i),
    .div_sel_i           (div_sel_i),
    .baud_range_select_i (baud_r),
    .basic_tick_o        (basic_tick),
    .ext_tick_o          (ext_tick)
  );

  wire        extend     = sticky_r || temp_r;
  wire [3:0]  xsleep     = extend ? pcs_pkg::XSLEEP_EXT : pcs_pkg::XSLEEP_NORM;
  wire [17:0] sleep_len  = 18'(sleep_field_r * xsleep * 18'(pcs_pkg::SLEEP_UNIT));
  wire        perm_sleep = (sleep_field_r == pcs_pkg::SLEEP_PERM);
  wire        sleep_done = !perm_sleep && basic_tick && (cnt_r + 18'h1 >= sleep_len);
  // start-up counted on the extended clock
  wire        start_done = ext_tick && (cnt_r + 18'h1 >= 18'(pcs_pkg::STARTUP_XCLK));
  wire        leave_sleep = (state_r == pcs_pkg::PCS_SLEEP) && (sleep_done || (sleep_len == 18'h0 && !perm_sleep));

  // operating mode register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sleep_field_r <= 5'h00;
      baud_r        <= 2'h0;
      sticky_r      <= 1'b0;
    end else if (operating_mode_register_wr_i) begin
      sleep_field_r <= sleep_field_i;
      baud_r        <= {baud_range_bit_high_i, baud_range_bit_low_i};
      sticky_r      <= sticky_sleep_extension_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) temp_r <= 1'b0;
    else if (operating_mode_register_wr_i) temp_r <= temporary_sleep_extension_i;
    else if (state_r == pcs_pkg::PCS_CHECK && check_fail_i) temp_r <= 1'b0;
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pcs_pkg::PCS_SLEEP:   if (leave_sleep) state_nxt = pcs_pkg::PCS_STARTUP;
      pcs_pkg::PCS_STARTUP: if (start_done) state_nxt = pcs_pkg::PCS_CHECK;
      pcs_pkg::PCS_CHECK: begin
        if (check_fail_i) state_nxt = pcs_pkg::PCS_SLEEP;
        else if (check_pass_i) state_nxt = pcs_pkg::PCS_RECEIVE;
      end
      pcs_pkg::PCS_RECEIVE: state_nxt = pcs_pkg::PCS_RECEIVE;
    endcase
    if (!polling_en_i) state_nxt = pcs_pkg::PCS_SLEEP;
  end

  // state and phase counter
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= pcs_pkg::PCS_SLEEP;
      cnt_r   <= 18'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || operating_mode_register_wr_i) cnt_r <= 18'h0;
      else if ((state_r == pcs_pkg::PCS_SLEEP && basic_tick) ||
               (state_r == pcs_pkg::PCS_STARTUP && ext_tick)) cnt_r <= cnt_r + 18'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      basic_tick_o   <= 1'b0;
      ext_tick_o     <= 1'b0;
      proc_en_o      <= 1'b0;
      check_active_o <= 1'b0;
      rx_data_o      <= 1'b0;
      receiving_o    <= 1'b0;
      perm_sleep_o   <= 1'b0;
      temp_ext_o     <= 1'b0;
      phase_o        <= 2'h0;
    end else begin
      basic_tick_o   <= basic_tick;
      ext_tick_o     <= ext_tick;
      proc_en_o      <= state_nxt != pcs_pkg::PCS_SLEEP;
      check_active_o <= state_nxt == pcs_pkg::PCS_CHECK;
      rx_data_o      <= (state_nxt == pcs_pkg::PCS_CHECK || state_nxt == pcs_pkg::PCS_RECEIVE) && rx_data_i;
      receiving_o    <= state_nxt == pcs_pkg::PCS_RECEIVE;
      perm_sleep_o   <= perm_sleep;
      temp_ext_o     <= temp_r;
      phase_o        <= state_nxt;
    end
  end

  property p_sticky_ext;
    @(posedge core_clk_i) disable iff (!rstn_i) sticky_r |-> (sleep_len == {sleep_field_r, 13'h0});
  endproperty
  a_sticky_ext: assert property (p_sticky_ext) else $error("sticky extension not applied");

  property p_temp_clear;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_CHECK && check_fail_i && !operating_mode_register_wr_i) |=> !temp_r;
  endproperty
  a_temp_clear: assert property (p_temp_clear) else $error("temporary extension not cleared");

  property p_perm_sleep;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_SLEEP && perm_sleep && polling_en_i) |=> state_r == pcs_pkg::PCS_SLEEP;
  endproperty
  a_perm_sleep: assert property (p_perm_sleep) else $error("left permanent sleep");

  property p_fail_sleep;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_CHECK && check_fail_i) |=> state_r == pcs_pkg::PCS_SLEEP;
  endproperty
  a_fail_sleep: assert property (p_fail_sleep) else $error("failed check did not sleep");

  sequence s_sleep_to_start;
    state_r == pcs_pkg::PCS_SLEEP ##1 state_r == pcs_pkg::PCS_STARTUP;
  endsequence
  property p_order;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_STARTUP && $past(state_r) != pcs_pkg::PCS_STARTUP) |-> $past(state_r) == pcs_pkg::PCS_SLEEP;
  endproperty
  a_order: assert property (p_order) else $error("start-up not entered from sleep");

  property p_ignore;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_SLEEP || state_r == pcs_pkg::PCS_STARTUP) |-> !check_active_o && !rx_data_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("check active outside check phase");

  property p_proc_en;
    @(posedge core_clk_i) disable iff (!rstn_i) s_sleep_to_start |=> proc_en_o;
  endproperty
  a_proc_en: assert property (p_proc_en) else $error("processing not enabled in start-up");

  property p_sleep_len;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_SLEEP) |-> (sleep_len == 18'(sleep_field_r * xsleep) << 10);
  endproperty
  a_sleep_len: assert property (p_sleep_len) else $error("sleep length wrong");

  property p_phase_out;
    @(posedge core_clk_i) disable iff (!rstn_i)
      phase_o == state_r;
  endproperty
  a_phase_out: assert property (p_phase_out) else $error("phase output differs from state");

  property p_proc_out;
    @(posedge core_clk_i) disable iff (!rstn_i)
      proc_en_o == (state_r != pcs_pkg::PCS_SLEEP);
  endproperty
  a_proc_out: assert property (p_proc_out) else $error("processing enable wrong");

  property p_check_out;
    @(posedge core_clk_i) disable iff (!rstn_i)
      check_active_o == (state_r == pcs_pkg::PCS_CHECK);
  endproperty
  a_check_out: assert property (p_check_out) else $error("check flag wrong");

  property p_rx_pass;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_CHECK || state_r == pcs_pkg::PCS_RECEIVE) |-> rx_data_o == $past(rx_data_i);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("data not passed in check or receive");

  property p_start_len;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_STARTUP && start_done && polling_en_i) |=> state_r == pcs_pkg::PCS_CHECK;
  endproperty
  a_start_len: assert property (p_start_len) else $error("start-up did not end in check");

  property p_no_early_check;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_STARTUP && !start_done) |=> state_r != pcs_pkg::PCS_CHECK;
  endproperty
  a_no_early_check: assert property (p_no_early_check) else $error("check began before settling");

  property p_sleep_hold;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_SLEEP && !leave_sleep) |=> state_r == pcs_pkg::PCS_SLEEP;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left early");

  property p_sleep_exit;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_SLEEP && leave_sleep && polling_en_i) |=> state_r == pcs_pkg::PCS_STARTUP;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep end did not start up");

  property p_pass_rx;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_CHECK && check_pass_i && !check_fail_i && polling_en_i)
        |=> state_r == pcs_pkg::PCS_RECEIVE;
  endproperty
  a_pass_rx: assert property (p_pass_rx) else $error("passed check did not receive");

  property p_poll_off;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !polling_en_i |=> state_r == pcs_pkg::PCS_SLEEP;
  endproperty
  a_poll_off: assert property (p_poll_off) else $error("polling off did not sleep");

  property p_temp_keep;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (temp_r && !operating_mode_register_wr_i && !(state_r == pcs_pkg::PCS_CHECK && check_fail_i)) |=> temp_r;
  endproperty
  a_temp_keep: assert property (p_temp_keep) else $error("temporary extension lost");

  property p_norm_len;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !extend |-> sleep_len == 18'({sleep_field_r, 10'h0});
  endproperty
  a_norm_len: assert property (p_norm_len) else $error("normal sleep length wrong");

  property p_temp_len;
    @(posedge core_clk_i) disable iff (!rstn_i)
      temp_r |-> sleep_len == {sleep_field_r, 13'h0};
  endproperty
  a_temp_len: assert property (p_temp_len) else $error("temporary sleep length wrong");

  property p_perm_out;
    @(posedge core_clk_i) disable iff (!rstn_i)
      $past(rstn_i) |-> perm_sleep_o == $past(perm_sleep);
  endproperty
  a_perm_out: assert property (p_perm_out) else $error("permanent sleep flag wrong");

  property p_temp_out;
    @(posedge core_clk_i) disable iff (!rstn_i)
      $past(rstn_i) |-> temp_ext_o == $past(temp_r);
  endproperty
  a_temp_out: assert property (p_temp_out) else $error("temporary flag output wrong");

  property p_recv_hold;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_r == pcs_pkg::PCS_RECEIVE && polling_en_i) |=> state_r == pcs_pkg::PCS_RECEIVE;
  endproperty
  a_recv_hold: assert property (p_recv_hold) else $error("receive left while polling");
endmodule

/* test/pcs_far_model.sv */
// far side model: crystal ticks and bit-check verdicts
// assumes check_active_i marks the check phase of the sequencer
`timescale 1ns/1ps
module pcs_far_model (
  // clock
  input  wire logic       core_clk_i,
  // check phase from the sequencer, verdict control from the bench
  input  wire logic       check_active_i,
  input  wire logic [1:0] verdict_i,
  input  wire logic [3:0] delay_i,
  // toward the sequencer
  output logic            xtal_tick_o,
  output logic            check_pass_o,
  output logic            check_fail_o
);
  int wait_r;
  initial begin
    {xtal_tick_o, check_pass_o, check_fail_o} = 3'h0;
    wait_r = 0;
  end
  // crystal pulse every other cycle, verdict once per check
  always @(negedge core_clk_i) begin
    xtal_tick_o <= ~xtal_tick_o;
    check_pass_o <= 1'b0;
    check_fail_o <= 1'b0;
    wait_r <= check_active_i ? wait_r + 1 : 0;
    if (check_active_i && wait_r == int'(delay_i)) begin
      check_fail_o <= (verdict_i == 2'h1);
      check_pass_o <= (verdict_i == 2'h2);
    end
  end
endmodule

/* test/polling_clock_sequencer_tb_top.sv */
// top testbench for the polling sequencer
// assumes the far model supplies crystal ticks and check verdicts
`timescale 1ns/1ps
module polling_clock_sequencer_tb_top;
  logic       core_clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       xtal_tick_i, check_pass_i, check_fail_i, rq;
  logic       div_sel_i = 1'b0, operating_mode_register_wr_i = 1'b0, rx_data_i = 1'b0, polling_en_i = 1'b0;
  logic [4:0] sleep_field_i = 5'h00;
  logic [1:0] range_v = 2'h0, verdict_v = 2'h1, phase_o;
  logic       sticky_v = 1'b0, temp_v = 1'b0;
  logic [3:0] delay_v = 4'h0;
  logic       basic_tick_o, ext_tick_o, proc_en_o, check_active_o, rx_data_o, receiving_o, perm_sleep_o, temp_ext_o;
  int         failures = 0, comparisons = 0, cyc_n = 0, bt_cnt = 0, et_cnt = 0, p, b0;

  pcs_top uut (.core_clk_i, .rstn_i, .xtal_tick_i, .div_sel_i, .operating_mode_register_wr_i, .sleep_field_i,
    .baud_range_bit_low_i(range_v[0]), .baud_range_bit_high_i(range_v[1]), .sticky_sleep_extension_i(sticky_v),
    .temporary_sleep_extension_i(temp_v), .polling_en_i, .check_pass_i, .check_fail_i, .rx_data_i,
    .basic_tick_o, .ext_tick_o, .proc_en_o, .check_active_o, .rx_data_o, .receiving_o, .perm_sleep_o,
    .temp_ext_o, .phase_o);
  pcs_far_model far (.core_clk_i, .check_active_i(check_active_o), .verdict_i(verdict_v), .delay_i(delay_v),
    .xtal_tick_o(xtal_tick_i), .check_pass_o(check_pass_i), .check_fail_o(check_fail_i));

  always #20 core_clk_i = ~core_clk_i;
  // tick counters and run limit
  always @(posedge core_clk_i) begin
    cyc_n <= cyc_n + 1;
    bt_cnt <= bt_cnt + int'(basic_tick_o === 1'b1);
    et_cnt <= et_cnt + int'(ext_tick_o === 1'b1);
    if (cyc_n == 80000) begin
      failures = failures + 1;
      final_report();
    end
  end
  always @(negedge core_clk_i) rx_data_i <= 1'($urandom);

  // expected extended period in core cycles, crystal pulse every 2 cycles
  function automatic int ext_per(input int d, input int r);
    return 2 * (d ? pcs_pkg::DIV_HIGH : pcs_pkg::DIV_LOW) * (8 >> r);
  endfunction
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp, input int tol);
    comparisons++;
    if (got > exp + tol || got < exp - tol) begin
      failures++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // mode write with polling held off, then polling on
  task automatic wr(input logic [4:0] s, input logic [1:0] r, input logic st, input logic tp);
    @(negedge core_clk_i);
    {sleep_field_i, range_v, sticky_v, temp_v, operating_mode_register_wr_i, polling_en_i} = {s, r, st, tp, 2'h2};
    @(negedge core_clk_i);
    {operating_mode_register_wr_i, polling_en_i} = 2'h1;
  endtask
  task automatic wait_phase(input logic [1:0] ph, input int lim);
    int n;
    n = 0;
    while (phase_o !== ph && n < lim) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(phase_o, ph);
  endtask
  task automatic period(input logic ext, output int q);
    int t0;
    t0 = 0;
    repeat (3) begin
      @(negedge core_clk_i);
      while ((ext ? ext_tick_o : basic_tick_o) !== 1'b1) @(negedge core_clk_i);
      q = cyc_n - t0;
      t0 = cyc_n;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    p = $urandom(21);
    repeat (20) @(negedge core_clk_i);
    chk(phase_o, 2'h0);
    chk({receiving_o, proc_en_o}, 2'h0);
    rstn_i = 1'b1;
    for (int d = 0; d < 2; d++) begin
      for (int r = 0; r < 4; r++) begin
        @(negedge core_clk_i);
        div_sel_i = 1'(d);
        wr(5'h00, 2'(r), 1'b0, 1'b0);
        period(1'b0, p);
        chk_n(p, ext_per(d, 3), 0);
        period(1'b1, p);
        chk_n(p, ext_per(d, r), 0);
      end
    end
    $display("test clock dividers done");
    for (int r = 0; r < 4; r++) begin
      delay_v = 4'($urandom);
      wr(5'h00, 2'(r), 1'b0, 1'b0);
      wait_phase(2'h1, 4000);
      b0 = et_cnt;
      chk({proc_en_o, rx_data_o}, 2'h2);
      wait_phase(2'h2, 4000);
      chk_n(et_cnt - b0, pcs_pkg::STARTUP_XCLK, 1);
      chk({check_active_o, proc_en_o}, 2'h3);
      wait_phase(2'h0, 100);
      wait_phase(2'h1, 100);
    end
    $display("test polling loop done");
    verdict_v = 2'h2;
    wr(5'h00, 2'h3, 1'b0, 1'b1);
    // flag output lags the mode write by one cycle
    @(negedge core_clk_i);
    chk({1'b0, temp_ext_o}, 2'h1);
    wait_phase(2'h3, 2000);
    chk({receiving_o, temp_ext_o}, 2'h3);
    @(posedge core_clk_i);
    rq = rx_data_i;
    @(negedge core_clk_i);
    chk({1'b0, rx_data_o}, {1'b0, rq});
    verdict_v = 2'h1;
    wr(5'h00, 2'h3, 1'b0, 1'b1);
    wait_phase(2'h2, 2000);
    wait_phase(2'h0, 100);
    @(negedge core_clk_i);
    chk({1'b0, temp_ext_o}, 2'h0);
    $display("test temporary extension done");
    // divide by 10: basic period of 20 cycles keeps the sleep tests short
    div_sel_i = 1'b0;
    wr(5'h01, 2'h3, 1'b0, 1'b0);
    b0 = bt_cnt;
    wait_phase(2'h1, 30000);
    chk_n(bt_cnt - b0, pcs_pkg::SLEEP_UNIT, 2);
    wr(5'h01, 2'h3, 1'b1, 1'b0);
    // an unextended sleep would sit in start-up at this point
    repeat (20640) @(negedge core_clk_i);
    chk(phase_o, 2'h0);
    $display("test sleep length done");
    wr(pcs_pkg::SLEEP_PERM, 2'h3, 1'b0, 1'b0);
    repeat (3000) @(negedge core_clk_i);
    chk({perm_sleep_o, proc_en_o}, 2'h2);
    wr(5'h00, 2'h3, 1'b0, 1'b0);
    wait_phase(2'h1, 100);
    $display("test permanent sleep done");
    final_report();
  end
endmodule
